// ---- ccmc_pkg.sv ----
/*
  Shared definitions for the counter configuration and minor command block:
  register selects, word layouts, opcodes, option bit positions and timing.
  Assumes a single 100 MHz system clock and a 16-bit host register port.
*/
package ccmc_pkg;

  // Port widths.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W = 5;

  // Register select codes on the register select lines.
  localparam logic [4:0] SEL_SEQ_CFG = 5'h08;
  localparam logic [4:0] SEL_PAIR_CFG = 5'h09;
  localparam logic [4:0] SEL_MINOR = 5'h0A;
  localparam logic [4:0] SEL_MAJOR = 5'h0B;
  localparam logic [4:0] SEL_SEQ_UPD = 5'h0C;
  localparam logic [4:0] SEL_LO_UPD = 5'h0D;
  localparam logic [4:0] SEL_HI_UPD = 5'h0E;
  localparam logic [4:0] SEL_FLAGS = 5'h10;
  localparam logic [4:0] SEL_SEQ_CAP = 5'h11;
  localparam logic [4:0] SEL_LO_VAL = 5'h12;
  localparam logic [4:0] SEL_HI_VAL = 5'h13;
  localparam logic [4:0] SEL_REQ = 5'h14;

  // Minor opcodes in bits 15 to 12 of the minor command word.
  localparam logic [3:0] OP_CLR_LO = 4'h0;
  localparam logic [3:0] OP_CLR_HI = 4'h1;
  localparam logic [3:0] OP_SET_LO = 4'h2;
  localparam logic [3:0] OP_SET_HI = 4'h3;
  localparam logic [3:0] OP_RUN_CLR = 4'h4;
  localparam logic [3:0] OP_RUN_SET = 4'h5;
  localparam logic [3:0] OP_AUX = 4'h6;
  localparam logic [3:0] OP_RESET = 4'h7;

  // Option bit positions.
  localparam int unsigned OPT_BEGIN = 7;
  localparam int unsigned OPT_UPD_SEQ = 0;
  localparam int unsigned OPT_OP_SEQ = 1;
  localparam int unsigned OPT_CAP_SEQ = 2;
  localparam int unsigned OPT_UPD_LO = 4;
  localparam int unsigned OPT_UPD_HI = 5;
  localparam int unsigned OPT_RST_ALL = 0;
  localparam int unsigned OPT_RST_FLAGS = 1;
  localparam int unsigned OPT_RST_REQ = 3;
  localparam logic [7:0] LOW_FLAG_MASK = 8'h3F;
  localparam logic [3:0] REQ_MASK = 4'hF;

  // Request flag positions.
  localparam int unsigned REQ_SUSP = 0;
  localparam int unsigned REQ_END = 1;

  // Sequence counter operate codes.
  localparam logic [2:0] SEQ_OP_SENT = 3'h2;
  localparam logic [2:0] SEQ_OP_ALIVE = 3'h3;
  localparam logic [2:0] SEQ_OP_DET_A = 3'h4;
  localparam logic [2:0] SEQ_OP_DET_B = 3'h5;
  localparam logic [2:0] SEQ_OP_LOW = 3'h6;
  localparam logic [2:0] SEQ_OP_HIGH = 3'h7;

  // Counter-use codes.
  localparam logic [1:0] USE_LO_ONLY = 2'h0;
  localparam logic [1:0] USE_TIER = 2'h2;
  localparam logic [1:0] USE_CAT = 2'h3;

  // Minor command duration.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MINOR_TIME_NS = 30;
  localparam int unsigned MINOR_CYCLES_DEF =
    (MINOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequence counter configuration word.
  typedef struct packed {
    logic [7:0] unused;
    logic [1:0] src;
    logic [2:0] op;
    logic reload;
    logic end_en;
    logic susp_en;
  } ccmc_seq_cfg_s;

  // Counter pair configuration word.
  typedef struct packed {
    logic [1:0] hi_src;
    logic hi_rise;
    logic hi_reload;
    logic hi_upd_inh;
    logic [1:0] aux_use;
    logic ext_en;
    logic [1:0] lo_src;
    logic lo_rise;
    logic lo_reload;
    logic lo_upd_inh;
    logic [1:0] ext_src;
    logic ext_pol;
  } ccmc_pair_cfg_s;

  // Minor command word.
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] null_bits;
    logic [7:0] opt;
  } ccmc_minor_s;

  // Host register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] sel;
    logic [15:0] wdata;
  } ccmc_host_req_s;

  // Execute-side inputs from the sequencer and event detectors.
  typedef struct packed {
    logic state_sent;
    logic alive;
    logic [3:0] det_hit;
  } ccmc_exec_in_s;

  typedef enum logic {ST_IDLE, ST_BUSY} ccmc_state_e;

endpackage : ccmc_pkg

// ---- ccmc_down_counter.sv ----
/*
  Down counter with update register load, reload or wrap on passing zero.
  Assumes its controls come from logic on the same clock.
*/
`timescale 1ns/1ps
module ccmc_down_counter #(
  parameter int unsigned W = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Controls.
  input wire logic clr,
  input wire logic op,
  input wire logic upd,
  input wire logic reload,
  input wire logic [W-1:0] upd_val,
  // Results.
  output logic [W-1:0] value,
  output logic pass_zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } ccmc_cnt_s;

  ccmc_cnt_s cnt_reg;
  ccmc_cnt_s cnt_next;

  initial begin
    if (W < 2) $error("ccmc_down_counter needs W of at least 2.");
  end

  // Clear beats update, update beats a decrement in the same cycle.
  always_comb begin
    cnt_next = cnt_reg;
    pass_zero = op && !clr && !upd && (cnt_reg.cnt == '0); // R24
    if (clr) begin
      cnt_next.cnt = '0;
    end else if (upd) begin
      cnt_next.cnt = upd_val;
    end else if (op) begin
      if (pass_zero) begin
        cnt_next.cnt = reload ? upd_val : '1; // R01
      end else begin
        cnt_next.cnt = cnt_reg.cnt - 1'b1; // R24
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign value = cnt_reg.cnt;

endmodule : ccmc_down_counter

// ---- ccmc_top.sv ----
/*
  Counter configuration registers, three event counters and the minor
  command executor of the test-bus controller.
  Assumes the host register port is driven by logic on clk_sys and that
  the event pins are asynchronous to it.
*/
`timescale 1ns/1ps

// Contract
// R01 - Counter passing zero reloads from update register or wraps to all ones.
// R02 - Three-bit operate field selects when the sequence counter counts.
// R03 - Two-bit source field picks pin or detector 0 to 3 for sequence counter.
// R04 - Polarity bit picks low or high level for external updating.
// R05 - Two-bit source field picks the event pin for external updating.
// R06 - Update-inverted bit excludes an auxiliary counter from updating.
// R07 - Operate bit picks falling or rising edges for an auxiliary counter.
// R08 - Two-bit source field picks the pin operating an auxiliary counter.
// R09 - External updating happens only while its enable bit is one.
// R10 - Counter-use field makes aux counters separate, tiered or concatenated.
// R11 - Use code 00 lets only the low aux counter update externally.
// R12 - Counter pair configuration word sits at select 01001.
// R13 - Host-written words are never changed by the device.
// R14 - Minor command word sits at select 01010.
// R15 - Each write of the minor command word starts that command.
// R16 - Command-in-progress pin is high while a minor command runs.
// R17 - Minor commands leave awake, alive and finish flag alone.
// R18 - Run-and-request commands with begin option start the major command.
// R19 - Opcode bits 15 to 12 decode eight minor commands; 1XXX does nothing.
// R20 - Opcode 0000 clears flags 5 to 0 where option bits are set.
// R21 - Opcode 0001 clears flags 15 to 8 from option bits 7 to 0.
// R22 - Option bits of zero leave their action undone.
// R23 - Sequence counter passing zero sets suspend request when enabled.
// R24 - Counters decrement by one; passing zero is decrementing from zero.
// R25 - Tiered high aux counter is operated by low one passing zero.
module ccmc_top
  import ccmc_pkg::*;
#(
  parameter int unsigned MINOR_CYCLES = ccmc_pkg::MINOR_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host register port.
  input wire ccmc_pkg::ccmc_host_req_s host_req,
  output logic [15:0] host_rdata,
  output logic cmd_busy,
  // Event pins and execute-side inputs.
  input wire logic [3:0] event_pins,
  input wire ccmc_pkg::ccmc_exec_in_s exec_in,
  input wire logic [15:0] hw_flag_set,
  // Results for the rest of the controller.
  output logic [15:0] interrupt_flag_word,
  output logic [3:0] request_flags,
  output logic major_start,
  output logic [15:0] major_word,
  output logic [2:0] zero_pulse
);

  import ccmc_pkg::*;

  // All block state apart from the counters themselves.
  typedef struct packed {
    ccmc_state_e state;
    logic [3:0] busy_cnt;
    logic busy;
    ccmc_seq_cfg_s seq_cfg;
    ccmc_pair_cfg_s pair_cfg;
    ccmc_minor_s minor;
    logic [15:0] major;
    logic [15:0] seq_upd;
    logic [15:0] lo_upd;
    logic [15:0] hi_upd;
    logic [15:0] flags;
    logic [15:0] seq_cap;
    logic [3:0] req;
    logic [3:0] ev_s1;
    logic [3:0] ev_s2;
    logic [3:0] ev_d;
    logic [15:0] rdata;
    logic major_start;
    logic [2:0] zero_pulse;
  } ccmc_state_s;

  ccmc_state_s st_reg;
  ccmc_state_s st_next;

  // Counter controls and values.
  logic [15:0] seq_val;
  logic [15:0] lo_val;
  logic [15:0] hi_val;
  logic seq_pz;
  logic lo_pz;
  logic hi_pz;
  logic seq_op;
  logic seq_upd_go;
  logic lo_op;
  logic lo_upd_go;
  logic lo_reload_eff;
  logic hi_op;
  logic hi_upd_go;
  logic cnt_clr;

  // Decoded minor command actions, valid in the write cycle only.
  logic minor_go;
  logic [7:0] opt;
  logic [3:0] opc;
  logic [15:0] flag_clr;
  logic [15:0] flag_set;
  logic [3:0] req_clr;
  logic [3:0] req_set;
  logic soft_all;

  // Pin levels and edges after synchronising.
  logic [3:0] ev_lvl;
  logic [3:0] ev_rise;
  logic [3:0] ev_fall;
  logic ext_upd;

  initial begin
    if (MINOR_CYCLES < 1 || MINOR_CYCLES > 15) begin
      $error("ccmc_top needs MINOR_CYCLES from 1 to 15.");
    end
  end

  // Read multiplexer; unmapped selects read as zero.
  function automatic logic [15:0] read_mux(input ccmc_state_s s, input logic [4:0] sel,
                                           input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = 16'h0000;
    unique case (sel)
      SEL_SEQ_CFG: r = s.seq_cfg;
      SEL_PAIR_CFG: r = s.pair_cfg;
      SEL_MINOR: r = s.minor;
      SEL_MAJOR: r = s.major;
      SEL_SEQ_UPD: r = s.seq_upd;
      SEL_LO_UPD: r = s.lo_upd;
      SEL_HI_UPD: r = s.hi_upd;
      SEL_FLAGS: r = s.flags;
      SEL_SEQ_CAP: r = s.seq_cap;
      SEL_LO_VAL: r = lo;
      SEL_HI_VAL: r = hi;
      SEL_REQ: r = {12'h000, s.req};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : read_mux

  // Only the second synchroniser stage and its delayed copy are looked at.
  assign ev_lvl = st_reg.ev_s2;
  assign ev_rise = st_reg.ev_s2 & ~st_reg.ev_d;
  assign ev_fall = ~st_reg.ev_s2 & st_reg.ev_d;

  // Level-sensitive external update on the chosen pin and polarity.
  assign ext_upd = st_reg.pair_cfg.ext_en // R09
                   && (ev_lvl[st_reg.pair_cfg.ext_src] == st_reg.pair_cfg.ext_pol); // R04 R05

  // Minor command decode straight from the write data.
  always_comb begin
    minor_go = host_req.wr && (host_req.sel == SEL_MINOR); // R14 R15
    opc = host_req.wdata[15:12];
    opt = host_req.wdata[7:0];
    flag_clr = 16'h0000;
    flag_set = 16'h0000;
    req_clr = 4'h0;
    req_set = 4'h0;
    soft_all = 1'b0;
    if (minor_go) begin
      // Only option bits that are one act; 1XXX opcodes match nothing.
      unique case (opc) // R19 R22
        OP_CLR_LO: flag_clr = {8'h00, opt & LOW_FLAG_MASK}; // R20
        OP_CLR_HI: flag_clr = {opt, 8'h00}; // R21
        OP_SET_LO: flag_set = {8'h00, opt & LOW_FLAG_MASK};
        OP_SET_HI: flag_set = {opt, 8'h00};
        OP_RUN_CLR: req_clr = opt[3:0];
        OP_RUN_SET: req_set = opt[3:0];
        OP_RESET: begin
          soft_all = opt[OPT_RST_ALL];
          if (opt[OPT_RST_FLAGS] || opt[OPT_RST_ALL]) flag_clr = 16'hFFFF;
          if (opt[OPT_RST_REQ] || opt[OPT_RST_ALL]) req_clr = REQ_MASK;
        end
        default: begin
          flag_clr = 16'h0000;
        end
      endcase
    end
  end

  // Sequence counter operation by the selected cause.
  always_comb begin
    seq_op = 1'b0;
    unique case (st_reg.seq_cfg.op) // R02
      SEQ_OP_SENT: seq_op = exec_in.state_sent;
      SEQ_OP_ALIVE: seq_op = exec_in.alive;
      SEQ_OP_DET_A, SEQ_OP_DET_B: seq_op = exec_in.det_hit[st_reg.seq_cfg.src]; // R03
      SEQ_OP_LOW: seq_op = !ev_lvl[st_reg.seq_cfg.src]; // R03
      SEQ_OP_HIGH: seq_op = ev_lvl[st_reg.seq_cfg.src];
      default: seq_op = 1'b0;
    endcase
    if (minor_go && opc == OP_AUX && opt[OPT_OP_SEQ]) seq_op = 1'b1;
    seq_upd_go = minor_go && opc == OP_AUX && opt[OPT_UPD_SEQ];
  end

  // Auxiliary counter operation, update and chaining.
  always_comb begin
    cnt_clr = soft_all;
    lo_op = st_reg.pair_cfg.lo_rise ? ev_rise[st_reg.pair_cfg.lo_src] // R07 R08
                                    : ev_fall[st_reg.pair_cfg.lo_src];
    hi_op = st_reg.pair_cfg.hi_rise ? ev_rise[st_reg.pair_cfg.hi_src] // R07 R08
                                    : ev_fall[st_reg.pair_cfg.hi_src];
    lo_reload_eff = st_reg.pair_cfg.lo_reload;
    if (st_reg.pair_cfg.aux_use == USE_TIER) begin
      hi_op = lo_pz; // R10 R25
    end else if (st_reg.pair_cfg.aux_use == USE_CAT) begin
      // The low half borrows into the high half; the whole reloads together.
      hi_op = lo_pz; // R10
      lo_reload_eff = (hi_val == 16'h0000) && st_reg.pair_cfg.hi_reload;
    end
    lo_upd_go = (ext_upd || (minor_go && opc == OP_AUX && opt[OPT_UPD_LO]))
                && !st_reg.pair_cfg.lo_upd_inh; // R06
    hi_upd_go = ((ext_upd && st_reg.pair_cfg.aux_use != USE_LO_ONLY) // R11
                 || (minor_go && opc == OP_AUX && opt[OPT_UPD_HI]))
                && !st_reg.pair_cfg.hi_upd_inh; // R06
  end

  // Next state of everything held in the state struct.
  always_comb begin
    st_next = st_reg;
    st_next.major_start = 1'b0;
    st_next.zero_pulse = {hi_pz, lo_pz, seq_pz};
    st_next.ev_s1 = event_pins;
    st_next.ev_s2 = st_reg.ev_s1;
    st_next.ev_d = st_reg.ev_s2;
    // Host writes; the device itself never alters these words.
    if (host_req.wr) begin
      unique case (host_req.sel) // R13
        SEL_SEQ_CFG: st_next.seq_cfg = host_req.wdata;
        SEL_PAIR_CFG: st_next.pair_cfg = host_req.wdata; // R12
        SEL_MINOR: st_next.minor = host_req.wdata; // R14
        SEL_MAJOR: st_next.major = host_req.wdata;
        SEL_SEQ_UPD: st_next.seq_upd = host_req.wdata;
        SEL_LO_UPD: st_next.lo_upd = host_req.wdata;
        SEL_HI_UPD: st_next.hi_upd = host_req.wdata;
        default: st_next.seq_upd = st_reg.seq_upd;
      endcase
    end
    // Flags: a hardware set in the clearing cycle wins over the clear.
    st_next.flags = (st_reg.flags & ~flag_clr) | flag_set | hw_flag_set; // R20 R21
    // Request flags, including those raised by the sequence counter.
    st_next.req = (st_reg.req & ~req_clr) | req_set;
    if (seq_pz && st_reg.seq_cfg.susp_en) st_next.req[REQ_SUSP] = 1'b1; // R23
    if (seq_pz && st_reg.seq_cfg.end_en) st_next.req[REQ_END] = 1'b1;
    // Begin the major command; awake, alive and finish stay with the sequencer.
    if (minor_go && (opc == OP_RUN_CLR || opc == OP_RUN_SET) && opt[OPT_BEGIN]) begin
      st_next.major_start = 1'b1; // R18 R17
    end
    if (minor_go && opc == OP_AUX && opt[OPT_CAP_SEQ]) begin
      st_next.seq_cap = seq_val;
    end
    if (soft_all) st_next.seq_cap = 16'h0000;
    // Busy spans a fixed number of cycles; a write while busy restarts it.
    unique case (st_reg.state)
      ST_IDLE: begin
        if (minor_go) begin
          st_next.state = ST_BUSY;
          st_next.busy = 1'b1; // R16
          st_next.busy_cnt = 4'(MINOR_CYCLES - 1);
        end
      end
      ST_BUSY: begin
        if (minor_go) begin
          st_next.busy_cnt = 4'(MINOR_CYCLES - 1);
        end else if (st_reg.busy_cnt == 4'h0) begin
          st_next.state = ST_IDLE;
          st_next.busy = 1'b0; // R16
        end else begin
          st_next.busy_cnt = st_reg.busy_cnt - 4'h1;
        end
      end
    endcase
    // Read data is registered and holds until the next read.
    if (host_req.rd) begin
      st_next.rdata = read_mux(st_reg, host_req.sel, lo_val, hi_val);
    end
  end

  // Configuration words reset to zero; the sequence counter is then idle, the aux counters count falling edges on pin 0.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Sequence counter.
  ccmc_down_counter #(.W(DATA_W)) u_seq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clr(cnt_clr),
    .op(seq_op),
    .upd(seq_upd_go),
    .reload(st_reg.seq_cfg.reload), // R01
    .upd_val(st_reg.seq_upd),
    .value(seq_val),
    .pass_zero(seq_pz)
  );

  // Low auxiliary counter.
  ccmc_down_counter #(.W(DATA_W)) u_lo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clr(cnt_clr),
    .op(lo_op),
    .upd(lo_upd_go),
    .reload(lo_reload_eff), // R01
    .upd_val(st_reg.lo_upd),
    .value(lo_val),
    .pass_zero(lo_pz)
  );

  // High auxiliary counter.
  ccmc_down_counter #(.W(DATA_W)) u_hi (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clr(cnt_clr),
    .op(hi_op),
    .upd(hi_upd_go),
    .reload(st_reg.pair_cfg.hi_reload), // R01
    .upd_val(st_reg.hi_upd),
    .value(hi_val),
    .pass_zero(hi_pz)
  );

  // Every output comes from a register of the state struct.
  assign host_rdata = st_reg.rdata;
  assign cmd_busy = st_reg.busy;
  assign interrupt_flag_word = st_reg.flags;
  assign request_flags = st_reg.req;
  assign major_start = st_reg.major_start;
  assign major_word = st_reg.major;
  assign zero_pulse = st_reg.zero_pulse;

endmodule : ccmc_top

// ---- ccmc_checker.sv ----
/*
  Concurrent checks on the ports of ccmc_top, bound into every instance.
  Assumes the single clk_sys domain and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
module ccmc_checker
  import ccmc_pkg::*;
#(
  parameter int unsigned MINOR_CYCLES = 3
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host port.
  input wire ccmc_pkg::ccmc_host_req_s host_req,
  input wire logic cmd_busy,
  input wire logic [15:0] hw_flag_set,
  // Results.
  input wire logic [15:0] interrupt_flag_word,
  input wire logic [3:0] request_flags,
  input wire logic major_start,
  input wire logic [15:0] major_word,
  input wire logic [2:0] zero_pulse
);
  logic minor_wr;
  logic run_wr;
  logic quiet;
  logic [3:0] busy_cnt_reg;

  // Command writes decoded once so the properties stay short.
  assign minor_wr = host_req.wr && (host_req.sel == SEL_MINOR);
  assign run_wr = minor_wr && (host_req.wdata[15:13] == 3'h2) && host_req.wdata[7];
  assign quiet = (hw_flag_set == 16'h0000);

  // Busy cycles since the last command write; a new write restarts the count.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_reg <= 4'h0;
    end else if (minor_wr || !cmd_busy) begin
      busy_cnt_reg <= 4'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 4'h1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_busy_start;
    minor_wr |=> cmd_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised by command");
  property p_busy_len;
    cmd_busy |-> (busy_cnt_reg < 4'(MINOR_CYCLES));
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy held too long");
  property p_busy_end;
    $fell(cmd_busy) |-> (busy_cnt_reg == 4'(MINOR_CYCLES));
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped early");
  property p_run_start;
    run_wr |=> major_start;
  endproperty
  a_run_start: assert property (p_run_start) else $error("major start missing");
  property p_start_cause;
    major_start |-> $past(run_wr);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("major start unprompted");
  property p_clr_lo;
    minor_wr && (host_req.wdata[15:12] == OP_CLR_LO) && quiet |=>
      interrupt_flag_word == ($past(interrupt_flag_word) & ~{10'h000, $past(host_req.wdata[5:0])});
  endproperty
  a_clr_lo: assert property (p_clr_lo) else $error("low flag clear wrong");
  property p_clr_hi;
    minor_wr && (host_req.wdata[15:12] == OP_CLR_HI) && quiet |=>
      interrupt_flag_word == ($past(interrupt_flag_word) & ~{$past(host_req.wdata[7:0]), 8'h00});
  endproperty
  a_clr_hi: assert property (p_clr_hi) else $error("high flag clear wrong");
  property p_void;
    minor_wr && host_req.wdata[15] && quiet |=>
      $stable(interrupt_flag_word) && $stable(request_flags) && !major_start;
  endproperty
  a_void: assert property (p_void) else $error("void opcode had an effect");
  property p_major_hold;
    !(host_req.wr && (host_req.sel == SEL_MAJOR)) |=> $stable(major_word);
  endproperty
  a_major_hold: assert property (p_major_hold) else $error("major word changed alone");

  c_minor: cover property (minor_wr);
  c_major: cover property (major_start);
  c_tier: cover property (zero_pulse[1] && zero_pulse[2]);
endmodule : ccmc_checker

bind ccmc_top ccmc_checker #(.MINOR_CYCLES(MINOR_CYCLES)) i_ccmc_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .host_req(host_req), .cmd_busy(cmd_busy),
  .hw_flag_set(hw_flag_set), .interrupt_flag_word(interrupt_flag_word),
  .request_flags(request_flags), .major_start(major_start),
  .major_word(major_word), .zero_pulse(zero_pulse)
);

// ---- ccmc_host_model.sv ----
/*
  Host processor model driving the register port of ccmc_top.
  Assumes its tasks are called one at a time from a single bench process.
*/
`timescale 1ns/1ps
module ccmc_host_model
  import ccmc_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Register port.
  output ccmc_pkg::ccmc_host_req_s host_req,
  input wire logic [15:0] host_rdata,
  input wire logic cmd_busy
);
  initial host_req = '0;

  // One strobe, raised after an edge and held until the edge that takes it.
  task automatic access(input logic w, input logic [4:0] s, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    host_req = '{wr: w, rd: !w, sel: s, wdata: d};
    @(posedge clk_sys);
    #1;
    // Released lines flip so a stale value is never taken for a live one.
    host_req = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
  endtask : access

  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    access(1'b1, s, d);
  endtask : wr

  task automatic rd(input logic [4:0] s, output logic [15:0] d);
    access(1'b0, s, 16'h0000);
    d = host_rdata;
  endtask : rd

  // Writes a command word, then waits out busy and reports its length.
  task automatic cmd(input logic [15:0] w, output int n);
    n = 0;
    access(1'b1, SEL_MINOR, w);
    while (cmd_busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask : cmd
endmodule : ccmc_host_model

// ---- tb_top.sv ----
/*
  Self-checking bench for ccmc_top through the host model's register tasks.
  Assumes ccmc_checker.sv is compiled too, so its bind takes effect.
*/
`timescale 1ns/1ps
module tb_top;
  import ccmc_pkg::*;
  localparam int unsigned MC = 3;
  logic clk_sys, sys_rst, cmd_busy, major_start;
  ccmc_host_req_s host_req;
  ccmc_exec_in_s exec_in;
  logic [15:0] host_rdata, hw_flag_set, interrupt_flag_word, major_word, rv;
  logic [3:0] event_pins, request_flags;
  logic [2:0] zero_pulse;
  int failures, n_tests, n_major, nb, nm;
  int n_zero[3];

  ccmc_top #(.MINOR_CYCLES(MC)) i_ccmc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .host_req(host_req), .host_rdata(host_rdata), .cmd_busy(cmd_busy),
    .event_pins(event_pins), .exec_in(exec_in), .hw_flag_set(hw_flag_set),
    .interrupt_flag_word(interrupt_flag_word), .request_flags(request_flags),
    .major_start(major_start), .major_word(major_word), .zero_pulse(zero_pulse));
  ccmc_host_model i_ccmc_host_model (.clk_sys(clk_sys), .host_req(host_req),
    .host_rdata(host_rdata), .cmd_busy(cmd_busy));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulse outputs are counted here because they last one cycle only.
  always @(posedge clk_sys) begin
    if (major_start === 1'b1) n_major++;
    for (int i = 0; i < 3; i++) if (zero_pulse[i] === 1'b1) n_zero[i]++;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string nm, input logic [4:0] s, input logic [15:0] e);
    i_ccmc_host_model.rd(s, rv);
    chk(nm, e, rv);
  endtask : rd_chk

  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    i_ccmc_host_model.wr(s, d);
  endtask : wr

  task automatic run(input logic [15:0] w);
    i_ccmc_host_model.cmd(w, nb);
    chk("busy cycles", 16'(MC), 16'(nb));
  endtask : run

  // Pin edges need the two-flop synchroniser and the edge stage to pass.
  task automatic pin_pulse(input int p);
    event_pins[p] = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 event_pins[p] = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : pin_pulse

  task automatic sent(input int n);
    repeat (n) begin
      exec_in.state_sent = 1'b1;
      @(posedge clk_sys);
      #1 exec_in.state_sent = 1'b0;
      @(posedge clk_sys);
      #1;
    end
  endtask : sent

  task automatic end_sim;
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // The whole run is a few hundred cycles; this limit catches a hang.
  initial begin
    #300000;
    failures++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    event_pins = 4'h0;
    exec_in = '0;
    hw_flag_set = 16'h0000;
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk("flags at reset", 16'h0000, interrupt_flag_word);
    // Configuration and major words keep what was written.
    wr(SEL_PAIR_CFG, 16'hA5C2);
    wr(SEL_MAJOR, 16'h3A5C);
    run(16'h30FF);
    run(16'h20FF);
    chk("set flags", 16'hFF3F, interrupt_flag_word);
    run(16'h00C5);
    chk("clear low", 16'hFF3A, interrupt_flag_word);
    run(16'h1081);
    rd_chk("clear high", SEL_FLAGS, 16'h7E3A);
    nm = n_major;
    for (int op = 8; op < 16; op++) run({4'(op), 12'h0FF});
    chk("void flags", 16'h7E3A, interrupt_flag_word);
    chk("void major", 16'(nm), 16'(n_major));
    run(16'h508F);
    chk("set req", 16'h000F, {12'h000, request_flags});
    run(16'h4085);
    chk("clear req", 16'h000A, {12'h000, request_flags});
    run(16'h5000);
    chk("major starts", 16'(nm + 2), 16'(n_major));
    run(16'h7008);
    chk("reset req", 16'h0000, {12'h000, request_flags});
    run(16'h7002);
    chk("reset flags", 16'h0000, interrupt_flag_word);
    rd_chk("pair cfg kept", SEL_PAIR_CFG, 16'hA5C2);
    chk("major kept", 16'h3A5C, major_word);
    // Sequence counter: load 2, three sent states, wrap past zero.
    wr(SEL_SEQ_UPD, 16'h0002);
    run(16'h6001);
    wr(SEL_SEQ_CFG, 16'h0011);
    sent(3);
    run(16'h6004);
    rd_chk("seq wrap", SEL_SEQ_CAP, 16'hFFFF);
    chk("seq zero", 16'h0001, 16'(n_zero[0]));
    chk("suspend req", 16'h0001, {12'h000, request_flags});
    wr(SEL_SEQ_CFG, 16'h0014);
    run(16'h6001);
    sent(3);
    run(16'h6004);
    rd_chk("seq reload", SEL_SEQ_CAP, 16'h0002);
    wr(SEL_SEQ_CFG, 16'h0004);
    sent(2);
    run(16'h6004);
    rd_chk("seq idle", SEL_SEQ_CAP, 16'h0002);
    wr(SEL_SEQ_CFG, 16'h00BC);
    pin_pulse(2);
    run(16'h6004);
    rd_chk("seq high", SEL_SEQ_CAP, 16'h0000);
    // Low aux counter on pin one, rising then falling edges.
    wr(SEL_PAIR_CFG, 16'h0060);
    wr(SEL_LO_UPD, 16'h0001);
    run(16'h6010);
    pin_pulse(1);
    pin_pulse(1);
    rd_chk("low rise", SEL_LO_VAL, 16'hFFFF);
    chk("low zero", 16'h0001, 16'(n_zero[1]));
    wr(SEL_PAIR_CFG, 16'h0040);
    pin_pulse(1);
    rd_chk("low fall", SEL_LO_VAL, 16'hFFFE);
    // Tiered: low passing zero steps the high counter.
    wr(SEL_PAIR_CFG, 16'h0440);
    wr(SEL_LO_UPD, 16'h0000);
    wr(SEL_HI_UPD, 16'h0000);
    run(16'h6030);
    pin_pulse(1);
    rd_chk("tier high", SEL_HI_VAL, 16'hFFFF);
    chk("high zero", 16'h0001, 16'(n_zero[2]));
    // External update from pin two, high level, then low level.
    wr(SEL_LO_UPD, 16'h1234);
    wr(SEL_PAIR_CFG, 16'h0205);
    pin_pulse(2);
    rd_chk("ext off", SEL_LO_VAL, 16'hFFFF);
    wr(SEL_PAIR_CFG, 16'h0305);
    pin_pulse(2);
    rd_chk("ext low", SEL_LO_VAL, 16'h1234);
    rd_chk("ext high", SEL_HI_VAL, 16'h0000);
    wr(SEL_HI_UPD, 16'h0009);
    wr(SEL_LO_UPD, 16'h00AA);
    wr(SEL_PAIR_CFG, 16'h010D);
    pin_pulse(2);
    rd_chk("ext high off", SEL_HI_VAL, 16'h0000);
    rd_chk("ext inhibit", SEL_LO_VAL, 16'h1234);
    wr(SEL_PAIR_CFG, 16'h0104);
    rd_chk("ext polarity", SEL_LO_VAL, 16'h00AA);
    end_sim();
  end
endmodule : tb_top
